// File: rtl/bst_test_port.sv
// boundary-scan test access port with a user register handed to the core clock
//
// Behaviour
// R1 - tester supplies a slow test clock, under 10 MHz, near 50% duty; the bench tester ticks every 48 ns, about 20.8 MHz.
// R2 - mode select is sampled on rising test clock edges and steers the controller.
// R3 - data input is sampled on rising edges into the selected shift register.
// R4 - data output comes from the selected shift register, changing on falling edges.
// R5 - data output is high impedance when no register is being shifted.
// R6 - output enable changes only after a falling test clock edge.
// R7 - low test reset holds the controller in reset and output high impedance.
// R8 - system should hold test reset low during power-up.
// R9 - tester keeps test reset high for any test operation; the bench tester drops it once in shift-dr to check R7.
// R10 - undriven mode select and data inputs read as one.
// R11 - sixteen-state controller; five rising edges with mode select high reach reset.
`timescale 1ns/10ps
`default_nettype none
module bst_test_port (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic test_clock,
  input wire logic test_reset_n,
  input wire logic test_mode_select,
  input wire logic test_mode_select_driven,
  input wire logic test_data_in,
  input wire logic test_data_in_driven,
  output logic test_data_out,
  output logic test_data_out_oe,
  output logic [bst_pkg::USER_W-1:0] user_word,
  output logic user_select
);

  // pad pullups: an undriven input reads one
  logic tms_eff;
  logic tdi_eff;
  assign tms_eff = test_mode_select_driven ? test_mode_select : 1'b1; // R10
  assign tdi_eff = test_data_in_driven ? test_data_in : 1'b1; // R10

  // test clock domain
  bst_pkg::bst_state_t state_r, state_nxt;
  bst_pkg::bst_ctl_t ctl;
  logic [bst_pkg::IR_W-1:0] ir_shift_r, ir_shift_nxt;
  logic [bst_pkg::IR_W-1:0] ir_r, ir_nxt;
  logic [bst_pkg::DR_W-1:0] dr_shift_r, dr_shift_nxt;
  logic [bst_pkg::USER_W-1:0] user_r, user_nxt;
  logic upd_tgl_r, upd_tgl_nxt;
  // registered select flag, so the crossing sees one clean flop and no decode glitch
  logic usel_r, usel_nxt;
  logic tdo_src;
  logic shifting;
  logic tdo_r;
  logic tdo_oe_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r) // R2 R11
      bst_pkg::ST_TLR: state_nxt = tms_eff ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: state_nxt = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: state_nxt = tms_eff ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: state_nxt = tms_eff ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: state_nxt = tms_eff ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: state_nxt = tms_eff ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: state_nxt = tms_eff ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: state_nxt = tms_eff ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: state_nxt = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_IR: state_nxt = tms_eff ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: state_nxt = tms_eff ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: state_nxt = tms_eff ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: state_nxt = tms_eff ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: state_nxt = tms_eff ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: state_nxt = tms_eff ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: state_nxt = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
    endcase
  end

  always_comb begin
    ctl.capture_dr = (state_r == bst_pkg::ST_CAP_DR);
    ctl.shift_dr = (state_r == bst_pkg::ST_SH_DR);
    ctl.update_dr = (state_r == bst_pkg::ST_UPD_DR);
    ctl.capture_ir = (state_r == bst_pkg::ST_CAP_IR);
    ctl.shift_ir = (state_r == bst_pkg::ST_SH_IR);
    ctl.update_ir = (state_r == bst_pkg::ST_UPD_IR);
  end

  // instruction path
  always_comb begin
    ir_shift_nxt = ir_shift_r;
    ir_nxt = ir_r;
    if (ctl.capture_ir) begin
      ir_shift_nxt = bst_pkg::IR_CAPTURE;
    end else if (ctl.shift_ir) begin
      ir_shift_nxt = {tdi_eff, ir_shift_r[bst_pkg::IR_W-1:1]}; // R3
    end
    if (ctl.update_ir) begin
      ir_nxt = ir_shift_r;
    end else if (state_r == bst_pkg::ST_TLR) begin
      ir_nxt = bst_pkg::IR_RESET;
    end
    usel_nxt = (ir_nxt == bst_pkg::IR_USER);
  end

  // data path: one shift register, length chosen by the instruction
  always_comb begin
    dr_shift_nxt = dr_shift_r;
    user_nxt = user_r;
    upd_tgl_nxt = upd_tgl_r;
    if (ctl.capture_dr) begin
      if (ir_r == bst_pkg::IR_IDCODE) begin
        dr_shift_nxt = bst_pkg::IDCODE_VAL;
      end else if (ir_r == bst_pkg::IR_USER) begin
        dr_shift_nxt = {{(bst_pkg::DR_W-bst_pkg::USER_W){1'b0}}, user_r};
      end else begin
        dr_shift_nxt = bst_pkg::DR_RESET;
      end
    end else if (ctl.shift_dr) begin
      if (ir_r == bst_pkg::IR_IDCODE) begin
        dr_shift_nxt = {tdi_eff, dr_shift_r[bst_pkg::DR_W-1:1]}; // R3
      end else if (ir_r == bst_pkg::IR_USER) begin
        dr_shift_nxt = {{(bst_pkg::DR_W-bst_pkg::USER_W){1'b0}}, tdi_eff,
                        dr_shift_r[bst_pkg::USER_W-1:1]}; // R3
      end else begin
        dr_shift_nxt = {{(bst_pkg::DR_W-1){1'b0}}, tdi_eff}; // R3
      end
    end
    if (ctl.update_dr && (ir_r == bst_pkg::IR_USER)) begin
      user_nxt = dr_shift_r[bst_pkg::USER_W-1:0];
      upd_tgl_nxt = ~upd_tgl_r;
    end
  end

  always_ff @(posedge test_clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      state_r <= bst_pkg::ST_TLR; // R7
      ir_shift_r <= bst_pkg::IR_RESET;
      ir_r <= bst_pkg::IR_RESET;
      dr_shift_r <= bst_pkg::DR_RESET;
      user_r <= bst_pkg::USER_RESET;
      upd_tgl_r <= 1'b0;
      usel_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ir_shift_r <= ir_shift_nxt;
      ir_r <= ir_nxt;
      dr_shift_r <= dr_shift_nxt;
      user_r <= user_nxt;
      upd_tgl_r <= upd_tgl_nxt;
      usel_r <= usel_nxt;
    end
  end

  // output stage on the falling edge
  always_comb begin
    shifting = ctl.shift_dr || ctl.shift_ir; // R5
    tdo_src = ctl.shift_ir ? ir_shift_r[0] : dr_shift_r[0]; // R4
  end

  always_ff @(negedge test_clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0; // R7
    end else begin
      tdo_r <= tdo_src; // R4
      tdo_oe_r <= shifting; // R6
    end
  end

  assign test_data_out = tdo_r;
  assign test_data_out_oe = tdo_oe_r;

  // core clock domain: toggle handshake for the user word, level sync for the select
  logic tgl_s1_r, tgl_s1_nxt;
  logic tgl_s2_r, tgl_s2_nxt;
  logic tgl_s3_r, tgl_s3_nxt;
  logic sel_s1_r, sel_s1_nxt;
  logic sel_s2_r, sel_s2_nxt;
  logic [bst_pkg::USER_W-1:0] user_word_r, user_word_nxt;

  always_comb begin
    tgl_s1_nxt = upd_tgl_r;
    tgl_s2_nxt = tgl_s1_r;
    tgl_s3_nxt = tgl_s2_r;
    sel_s1_nxt = usel_r;
    sel_s2_nxt = sel_s1_r;
    user_word_nxt = user_word_r;
    // user_r is stable for many core cycles after the toggle moves
    if (tgl_s2_r != tgl_s3_r) begin
      user_word_nxt = user_r;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
      user_word_r <= bst_pkg::USER_RESET;
    end else begin
      tgl_s1_r <= tgl_s1_nxt;
      tgl_s2_r <= tgl_s2_nxt;
      tgl_s3_r <= tgl_s3_nxt;
      sel_s1_r <= sel_s1_nxt;
      sel_s2_r <= sel_s2_nxt;
      user_word_r <= user_word_nxt;
    end
  end

  assign user_word = user_word_r;
  assign user_select = sel_s2_r;

  // checks
  sequence s_tms_high_run;
    tms_eff [*5];
  endsequence

  sequence s_enter_shift_dr;
    state_r == bst_pkg::ST_CAP_DR && !tms_eff;
  endsequence

  property p_tlr_after_ones;
    @(posedge test_clock) disable iff (!test_reset_n)
      s_tms_high_run |=> state_r == bst_pkg::ST_TLR;
  endproperty
  a_tlr_after_ones: assert property (p_tlr_after_ones) else $error("five ones did not reach reset state"); // R11

  property p_leave_tlr;
    @(posedge test_clock) disable iff (!test_reset_n)
      (state_r == bst_pkg::ST_TLR && !tms_eff) ##1 !tms_eff |=> state_r == bst_pkg::ST_RTI;
  endproperty
  a_leave_tlr: assert property (p_leave_tlr) else $error("controller did not settle in idle"); // R2

  property p_bypass_shift;
    @(posedge test_clock) disable iff (!test_reset_n)
      (ctl.shift_dr && ir_r == bst_pkg::IR_BYPASS) |=> dr_shift_r[0] == $past(tdi_eff);
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) else $error("bypass bit not taken from data input"); // R3

  property p_idcode_capture;
    @(posedge test_clock) disable iff (!test_reset_n)
      (s_enter_shift_dr and ir_r == bst_pkg::IR_IDCODE) |=> dr_shift_r == bst_pkg::IDCODE_VAL;
  endproperty
  a_idcode_capture: assert property (p_idcode_capture) else $error("identification word not captured"); // R3

  property p_out_from_ir;
    @(posedge test_clock) disable iff (!test_reset_n)
      ctl.shift_ir ##1 ctl.shift_ir |-> test_data_out == ir_shift_r[0];
  endproperty
  a_out_from_ir: assert property (p_out_from_ir) else $error("output not from instruction shift register"); // R4

  property p_oe_in_shift;
    @(posedge test_clock) disable iff (!test_reset_n)
      shifting |-> test_data_out_oe;
  endproperty
  a_oe_in_shift: assert property (p_oe_in_shift) else $error("output not driven while shifting"); // R6

  property p_hiz_idle;
    @(posedge test_clock) disable iff (!test_reset_n)
      !shifting |-> !test_data_out_oe;
  endproperty
  a_hiz_idle: assert property (p_hiz_idle) else $error("output driven with no register selected"); // R5

  property p_reset_hold;
    @(posedge core_clk) disable iff (!resetn)
      !test_reset_n |-> (!test_data_out_oe && state_r == bst_pkg::ST_TLR);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("test reset did not hold the port"); // R7

  property p_pullup_tdi;
    @(posedge test_clock) disable iff (!test_reset_n)
      (ctl.shift_dr && ir_r == bst_pkg::IR_BYPASS && !test_data_in_driven) |=> dr_shift_r[0];
  endproperty
  a_pullup_tdi: assert property (p_pullup_tdi) else $error("undriven data input not read as one"); // R10

  property p_user_cross;
    @(posedge core_clk) disable iff (!resetn)
      (tgl_s2_r != tgl_s3_r) |=> user_word_r == $past(user_r);
  endproperty
  a_user_cross: assert property (p_user_cross) else $error("user word not handed to core clock"); // R3

endmodule // bst_test_port
`default_nettype wire

// File: rtl/bst_pkg.sv
// package with the constants and types of the boundary-scan test port
package bst_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int USER_W = 8;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_USER = 4'h8;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = 4'h1;
  // identification word, value is arbitrary; bit 0 must be one
  localparam logic [DR_W-1:0] IDCODE_VAL = 32'h0000_0001;
  localparam logic [USER_W-1:0] USER_RESET = 8'h00;
  localparam logic [DR_W-1:0] DR_RESET = 32'h0000_0000;
  localparam int TLR_TMS_ONES = 5;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;

  typedef struct packed {
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } bst_ctl_t;
endpackage

// File: verif/bst_tester.sv
// tester model driving the boundary-scan port
`timescale 1ns/10ps
`default_nettype none
module bst_tester (
  output logic test_clock = 1'b0,
  output logic test_reset_n = 1'b0,
  output logic test_mode_select = 1'b1,
  output logic test_mode_select_driven = 1'b0,
  output logic test_data_in = 1'b1,
  output logic test_data_in_driven = 1'b0,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  output logic [31:0] rx_word = '0,
  output logic rx_done = 1'b0
);
  // reset starts low and is raised only by set_rst
  task automatic set_rst(input logic v);
    test_reset_n = v;
  endtask

  // one test clock period of 48 ns; clock rests low between ticks
  task automatic tick(input logic ms, input logic di, input logic fm, input logic fd, output logic so);
    test_mode_select = fm ? ~test_mode_select : ms;
    test_mode_select_driven = ~fm;
    test_data_in = fd ? ~test_data_in : di;
    test_data_in_driven = ~fd;
    #24;
    test_clock = 1'b1;
    so = (test_data_out_oe === 1'b1) ? test_data_out : 1'bx;
    #24;
    test_clock = 1'b0;
  endtask

  // full scan from idle back to idle, lsb first
  task automatic scan(input int n, input logic [31:0] d, input logic ir, input logic fl);
    logic s;
    logic [31:0] r;
    r = '0;
    tick(1'b1, 1'b0, 1'b0, 1'b0, s);
    if (ir) tick(1'b1, 1'b0, 1'b0, 1'b0, s);
    tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], 1'b0, fl, s);
      r[i] = s;
    end
    tick(1'b1, 1'b0, 1'b0, 1'b0, s);
    tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    rx_word = r;
    rx_done = ~rx_done;
  endtask
endmodule // bst_tester
`default_nettype wire

// File: verif/bst_test_port_bench.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
module bst_test_port_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  wire logic test_clock, test_reset_n, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, rx_done;
  wire logic [31:0] rx_word;
  wire logic [bst_pkg::USER_W-1:0] user_word;
  wire logic user_select;
  logic [31:0] exp_q[$];
  logic [31:0] exp_w;
  logic [7:0] val;
  logic s;
  int err_count = 0;
  int samples_checked = 0;

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  bst_test_port i_bst_test_port (.core_clk(core_clk), .resetn(resetn), .test_clock(test_clock),
    .test_reset_n(test_reset_n), .test_mode_select(tms), .test_mode_select_driven(tms_drv),
    .test_data_in(tdi), .test_data_in_driven(tdi_drv), .test_data_out(tdo), .test_data_out_oe(tdo_oe),
    .user_word(user_word), .user_select(user_select));
  bst_tester i_bst_tester (.test_clock(test_clock), .test_reset_n(test_reset_n), .test_mode_select(tms),
    .test_mode_select_driven(tms_drv), .test_data_in(tdi), .test_data_in_driven(tdi_drv),
    .test_data_out(tdo), .test_data_out_oe(tdo_oe), .rx_word(rx_word), .rx_done(rx_done));

  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // each captured scan word is matched to the oldest expectation
  initial begin
    forever begin
      @(rx_done);
      samples_checked++;
      if (exp_q.size() == 0) begin
        fail("scan word without expectation");
      end else begin
        exp_w = exp_q.pop_front();
        if (rx_word !== exp_w) fail("scan word differs");
      end
    end
  end

  task automatic scan(input int n, input logic [31:0] d, input logic ir, input logic [31:0] e, input logic fl = 1'b0);
    exp_q.push_back(e);
    i_bst_tester.scan(n, d, ir, fl);
  endtask

  task automatic oe_low(input string m);
    samples_checked++;
    if (tdo_oe !== 1'b0) fail(m);
  endtask

  // idle to shift-dr
  task automatic to_shift();
    i_bst_tester.tick(1'b1, 1'b0, 1'b0, 1'b0, s);
    i_bst_tester.tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    i_bst_tester.tick(1'b0, 1'b0, 1'b0, 1'b0, s);
  endtask

  initial begin
    #500000;
    fail("run timed out");
    results();
  end

  initial begin
    void'($urandom(32'h2a20c71f));
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    oe_low("data out driven in test reset");
    i_bst_tester.set_rst(1'b1);
    i_bst_tester.tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    i_bst_tester.tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    oe_low("data out driven while idle");
    scan(32, $urandom, 1'b0, bst_pkg::IDCODE_VAL);
    $display("test identification done");
    val = 8'($urandom);
    scan(4, {28'h0, bst_pkg::IR_USER}, 1'b1, {28'h0, bst_pkg::IR_CAPTURE});
    scan(8, {24'h0, val}, 1'b0, {24'h0, bst_pkg::USER_RESET});
    for (int i = 0; i < 20 && user_word !== val; i++) @(posedge core_clk);
    samples_checked++;
    if (user_word !== val || user_select !== 1'b1) fail("user word not delivered");
    scan(8, {24'h0, ~val}, 1'b0, {24'h0, val});
    $display("test user register done");
    scan(4, {28'h0, bst_pkg::IR_BYPASS}, 1'b1, {28'h0, bst_pkg::IR_CAPTURE});
    scan(9, {24'h0, val}, 1'b0, {23'h0, val, 1'b0});
    scan(9, 32'h0, 1'b0, 32'h1FE, 1'b1);
    $display("test bypass done");
    to_shift();
    i_bst_tester.set_rst(1'b0);
    #1;
    oe_low("data out driven after mid-scan reset");
    i_bst_tester.set_rst(1'b1);
    i_bst_tester.tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    scan(32, 32'h0, 1'b0, bst_pkg::IDCODE_VAL);
    $display("test mid-scan reset done");
    scan(4, {28'h0, bst_pkg::IR_BYPASS}, 1'b1, {28'h0, bst_pkg::IR_CAPTURE});
    to_shift();
    for (int i = 0; i < 5; i++) i_bst_tester.tick(1'b0, 1'b0, 1'b1, 1'b0, s);
    i_bst_tester.tick(1'b0, 1'b0, 1'b0, 1'b0, s);
    oe_low("data out driven after mode select reset");
    scan(32, 32'h0, 1'b0, bst_pkg::IDCODE_VAL);
    $display("test mode select reset done");
    #100;
    samples_checked++;
    if (exp_q.size() != 0) fail("scan words missing");
    results();
  end
endmodule // bst_test_port_bench
`default_nettype wire
